/* mrls_top.sv */
// Purpose: run control, test run and power-up switch capture of a motor driver
// Assumes: all switch and terminal inputs are asynchronous pins
// Notes:   adc code spans 0..10 V over 10 bits; speed outputs are in r/min
//
// The address map and the address-and-strobe port were chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
// How it works
// - test switch runs forward at 100 r/min
// - test switch off stops the motor
// - stored reversal flips test run direction
// - run input during test stops, no alarm
// - locked until test and run inputs off
// - switches sampled once after each reset release only
// - protocol switch selects modbus or converter
// - address is rotary plus 16 when high
// - rate switch codes 0..4 and 7
// - rate defaults to converter code 7
// - termination switch enables 120 ohm terminator
// - speed limited 100..4000 except while ramping down, starts at 0
// - analog span 0..5 V, optional 0..10 V
// - cw input runs cw (ccw when reversal stored), release stops
// - ccw input runs ccw (cw when reversal stored), release stops
// - both run inputs give instant stop while running or ramping down
// - terminals 0,1,2 are cw, ccw, stop style
// - thermostat trip raises regen overheat alarm
// - regen unit handled only if present early
// - stop style on decelerates, off instant
module mrls_top #(
    parameter int RAMP_TICKS = mrls_pkg::RAMP_TICK_CYC   // cycles per ramp step
) (
    input  wire logic        ref_clk_in,
    input  wire logic        rst_n_in,
    input  wire logic        test_run_switch_in,
    input  wire logic        input_terminal_zero_in,
    input  wire logic        input_terminal_one_in,
    input  wire logic        input_terminal_two_in,
    input  wire logic        protocol_select_switch_in,
    input  wire logic        address_high_switch_in,
    input  wire logic [3:0]  address_rotary_switch_in,
    input  wire logic [3:0]  bit_rate_switch_in,
    input  wire logic        termination_switch_in,
    input  wire logic        regen_present_in,
    input  wire logic        regen_thermostat_in,
    input  wire logic [9:0]  analog_speed_in,
    input  wire logic [3:0]  reg_addr_in,
    input  wire logic [15:0] reg_wdata_in,
    input  wire logic        reg_wr_in,
    input  wire logic        reg_rd_in,
    output logic [15:0]      reg_rdata_out,
    output logic [11:0]      speed_cmd_out,
    output logic             motor_run_out,
    output logic             motor_ccw_out,
    output logic             instant_stop_out,
    output logic             protocol_modbus_out,
    output logic [4:0]       node_address_out,
    output logic [3:0]       bit_rate_code_out,
    output logic             bit_rate_valid_out,
    output logic             termination_en_out,
    output logic             regen_alarm_out
);
    // ------------------------------------------------------------
    // reset release
    // ------------------------------------------------------------
    logic       rst_meta_r;     // first reset stage
    logic       rst_n;          // released reset used everywhere

    // two flops release the reset on the clock
    always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            rst_meta_r <= 1'b0;
            rst_n      <= 1'b0;
        end else begin
            rst_meta_r <= 1'b1;
            rst_n      <= rst_meta_r;
        end
    end

    // ------------------------------------------------------------
    // pin synchronisers
    // ------------------------------------------------------------
    localparam int NSYNC = 27;
    logic [NSYNC-1:0] pin_raw;      // all asynchronous pins together
    logic [NSYNC-1:0] pin_meta_r;   // first stage, read only by second
    logic [NSYNC-1:0] pin_r;        // safe copies

    assign pin_raw = {analog_speed_in, regen_thermostat_in, regen_present_in,
                      termination_switch_in, bit_rate_switch_in,
                      address_rotary_switch_in, address_high_switch_in,
                      protocol_select_switch_in, input_terminal_two_in,
                      input_terminal_one_in, input_terminal_zero_in,
                      test_run_switch_in};

    // two flop chain per pin
    always_ff @(posedge ref_clk_in or negedge rst_n) begin
        if (!rst_n) begin
            pin_meta_r <= '0;
            pin_r      <= '0;
        end else begin
            pin_meta_r <= pin_raw;
            pin_r      <= pin_meta_r;
        end
    end

    wire logic       test_sw     = pin_r[0];       // test run switch
    wire logic       cw_in       = pin_r[1];       // terminal zero
    wire logic       ccw_in      = pin_r[2];       // terminal one
    wire logic       decel_style = pin_r[3];       // terminal two
    wire logic       thermo      = pin_r[16];      // thermostat tripped
    wire logic [9:0] adc_code    = pin_r[26:17];   // analog speed code

    // ------------------------------------------------------------
    // power-up capture of switches
    // ------------------------------------------------------------
    mrls_pkg::mrls_cfg_s cfg_r, cfg_nxt;       // latched settings
    logic [1:0]          capt_cnt_r, capt_cnt_nxt;
    logic                capt_done_r, capt_done_nxt;

    // sample once, after the sync chain is full, never again
    always_comb begin
        cfg_nxt       = cfg_r;
        capt_cnt_nxt  = capt_cnt_r;
        capt_done_nxt = capt_done_r;
        if (!capt_done_r) begin
            if (capt_cnt_r == mrls_pkg::CAPT_WAIT) begin
                capt_done_nxt = 1'b1;
                cfg_nxt.modbus = pin_r[4];
                cfg_nxt.addr   = {1'b0, pin_r[9:6]}
                               | (pin_r[5] ? mrls_pkg::ADDR_HIGH
                                           : mrls_pkg::ADDR_DEFAULT);
                cfg_nxt.rate   = pin_r[13:10];
                cfg_nxt.term   = pin_r[14];
                cfg_nxt.regen  = pin_r[15];
            end else begin
                capt_cnt_nxt = capt_cnt_r + 2'h1;
            end
        end
    end

    // settings hold factory defaults until captured
    always_ff @(posedge ref_clk_in or negedge rst_n) begin
        if (!rst_n) begin
            cfg_r       <= mrls_pkg::CFG_RST;
            capt_cnt_r  <= 2'h0;
            capt_done_r <= 1'b0;
        end else begin
            cfg_r       <= cfg_nxt;
            capt_cnt_r  <= capt_cnt_nxt;
            capt_done_r <= capt_done_nxt;
        end
    end

    // ------------------------------------------------------------
    // register port
    // ------------------------------------------------------------
    logic [1:0]  ctrl_r, ctrl_nxt;      // reversal and span
    logic [11:0] decel_r, decel_nxt;    // ramp step
    logic [15:0] rdata_r, rdata_nxt;    // read answer
    mrls_pkg::mrls_state_e st_r, st_nxt;
    logic [11:0] speed_r, speed_nxt;
    logic        alarm_r, alarm_nxt;

    // decode writes and build the read answer
    always_comb begin
        ctrl_nxt  = ctrl_r;
        decel_nxt = decel_r;
        rdata_nxt = 16'h0000;
        if (reg_wr_in) begin
            case (reg_addr_in)
                mrls_pkg::REG_CTRL:  ctrl_nxt  = reg_wdata_in[1:0];
                mrls_pkg::REG_DECEL: decel_nxt = reg_wdata_in[11:0];
                default: ;                         // read-only or unmapped
            endcase
        end
        if (reg_rd_in) begin
            case (reg_addr_in)
                mrls_pkg::REG_CTRL:   rdata_nxt = {14'h0000, ctrl_r};
                mrls_pkg::REG_DECEL:  rdata_nxt = {4'h0, decel_r};
                mrls_pkg::REG_STATUS: rdata_nxt = {11'h000, capt_done_r, alarm_r,
                                                   st_r};
                mrls_pkg::REG_CONFIG: rdata_nxt = {4'h0, cfg_r};
                mrls_pkg::REG_SPEED:  rdata_nxt = {4'h0, speed_r};
                default:              rdata_nxt = 16'h0000;
            endcase
        end
    end

    // register file state
    always_ff @(posedge ref_clk_in or negedge rst_n) begin
        if (!rst_n) begin
            ctrl_r  <= mrls_pkg::CTRL_RST;
            decel_r <= mrls_pkg::DECEL_RST;
            rdata_r <= 16'h0000;
        end else begin
            ctrl_r  <= ctrl_nxt;
            decel_r <= decel_nxt;
            rdata_r <= rdata_nxt;
        end
    end

    // ------------------------------------------------------------
    // analog speed setpoint
    // ------------------------------------------------------------
    logic [21:0] prod5, prod10;    // code times full scale
    logic [21:0] scaled;           // r/min before clamping
    logic [11:0] setpoint;         // clamped setpoint
    logic [9:0]  code5;            // code limited to 5 V

    // scale and clamp the analog command
    always_comb begin
        code5  = (adc_code > mrls_pkg::ADC_HALF_MAX) ? mrls_pkg::ADC_HALF_MAX
                                                      : adc_code;
        prod5  = 22'({12'h000, code5} * {10'h000, mrls_pkg::SPEED_MAX});
        prod10 = 22'({12'h000, adc_code} * {10'h000, mrls_pkg::SPEED_MAX});
        scaled = ctrl_r[mrls_pkg::CTRL_SPAN] ? (prod10 >> mrls_pkg::SHIFT_10V)
                                             : (prod5 >> mrls_pkg::SHIFT_5V);
        if (scaled[11:0] < mrls_pkg::SPEED_MIN) begin
            setpoint = mrls_pkg::SPEED_MIN;
        end else begin
            setpoint = scaled[11:0];
        end
    end

    // ------------------------------------------------------------
    // ramp tick
    // ------------------------------------------------------------
    logic [31:0] tick_cnt_r, tick_cnt_nxt;
    logic        tick;

    // free running divider for the deceleration ramp
    always_comb begin
        tick         = (tick_cnt_r == 32'(RAMP_TICKS - 1));
        tick_cnt_nxt = tick ? 32'h0 : tick_cnt_r + 32'h1;
    end

    always_ff @(posedge ref_clk_in or negedge rst_n) begin
        if (!rst_n) begin
            tick_cnt_r <= 32'h0;
        end else begin
            tick_cnt_r <= tick_cnt_nxt;
        end
    end

    // ------------------------------------------------------------
    // run control
    // ------------------------------------------------------------
    logic run_r, run_nxt;          // motor energised
    logic ccw_r, ccw_nxt;          // rotation is counterclockwise
    logic istop_r, istop_nxt;      // one-cycle instant stop pulse
    wire logic both     = cw_in & ccw_in;                       // both run inputs on
    wire logic ccw_run_input      = ctrl_r[mrls_pkg::CTRL_REV];           // stored reversal
    wire logic released = (ccw_r ^ ccw_run_input) ? !ccw_in : !cw_in;     // starting input let go

    // run, stop and test sequencing
    always_comb begin
        st_nxt    = st_r;
        speed_nxt = speed_r;
        ccw_nxt   = ccw_r;
        istop_nxt = 1'b0;
        alarm_nxt = alarm_r | (cfg_r.regen & thermo);
        case (st_r)
            mrls_pkg::ST_IDLE: begin
                if (alarm_r || !capt_done_r) begin
                    st_nxt = mrls_pkg::ST_IDLE;                     // hold stopped
                end else if (test_sw && !cw_in && !ccw_in) begin
                    st_nxt    = mrls_pkg::ST_TEST;
                    ccw_nxt   = ccw_run_input;
                    speed_nxt = mrls_pkg::TEST_SPEED;
                end else if (test_sw) begin
                    st_nxt = mrls_pkg::ST_LOCK;                     // wait all off
                end else if (cw_in ^ ccw_in) begin                  // both stay idle
                    st_nxt    = mrls_pkg::ST_RUN;
                    ccw_nxt   = ccw_in ^ ccw_run_input;
                    speed_nxt = setpoint;
                end
            end
            mrls_pkg::ST_RUN: begin
                speed_nxt = setpoint;
                if (alarm_r || both || (released && !decel_style)) begin
                    st_nxt    = mrls_pkg::ST_IDLE;
                    istop_nxt = 1'b1;
                end else if (released) begin
                    st_nxt    = mrls_pkg::ST_DECEL;
                    speed_nxt = speed_r;
                end
            end
            mrls_pkg::ST_DECEL: begin
                if (alarm_r || both) begin
                    st_nxt    = mrls_pkg::ST_IDLE;
                    istop_nxt = 1'b1;
                end else if (tick && (speed_r <= decel_r)) begin
                    st_nxt = mrls_pkg::ST_IDLE;
                end else if (tick) begin
                    speed_nxt = speed_r - decel_r;
                end
            end
            mrls_pkg::ST_TEST: begin
                speed_nxt = mrls_pkg::TEST_SPEED;
                ccw_nxt   = ccw_run_input;
                if (alarm_r || !test_sw) begin
                    st_nxt = mrls_pkg::ST_IDLE;
                end else if (cw_in || ccw_in) begin
                    st_nxt = mrls_pkg::ST_LOCK;
                end
            end
            mrls_pkg::ST_LOCK: begin
                if (!test_sw && !cw_in && !ccw_in) begin
                    st_nxt = mrls_pkg::ST_IDLE;
                end
            end
            default: st_nxt = mrls_pkg::ST_IDLE;
        endcase
        // idle and lock never drive the motor and always show zero speed
        run_nxt = (st_nxt == mrls_pkg::ST_RUN) || (st_nxt == mrls_pkg::ST_DECEL)
                  || (st_nxt == mrls_pkg::ST_TEST);
        if (!run_nxt) begin
            speed_nxt = mrls_pkg::SPEED_INIT;
        end
    end

    // run control state
    always_ff @(posedge ref_clk_in or negedge rst_n) begin
        if (!rst_n) begin
            st_r    <= mrls_pkg::ST_IDLE;
            speed_r <= mrls_pkg::SPEED_INIT;
            run_r   <= 1'b0;
            ccw_r   <= 1'b0;
            istop_r <= 1'b0;
            alarm_r <= 1'b0;
        end else begin
            st_r    <= st_nxt;
            speed_r <= speed_nxt;
            run_r   <= run_nxt;
            ccw_r   <= ccw_nxt;
            istop_r <= istop_nxt;
            alarm_r <= alarm_nxt;
        end
    end

    // ------------------------------------------------------------
    // outputs, all straight from flops
    // ------------------------------------------------------------
    assign reg_rdata_out       = rdata_r;
    assign speed_cmd_out       = speed_r;
    assign motor_run_out       = run_r;
    assign motor_ccw_out       = ccw_r;
    assign instant_stop_out    = istop_r;
    assign regen_alarm_out     = alarm_r;
    assign protocol_modbus_out = cfg_r.modbus;
    assign node_address_out    = cfg_r.addr;
    assign bit_rate_code_out   = cfg_r.rate;
    assign termination_en_out  = cfg_r.term;

    // valid rate flag registers from the captured code, one cycle behind it
    logic rate_ok_r;
    always_ff @(posedge ref_clk_in or negedge rst_n) begin
        if (!rst_n) begin
            rate_ok_r <= 1'b1;
        end else begin
            rate_ok_r <= (cfg_r.rate <= mrls_pkg::RATE_115200)
                       || (cfg_r.rate == mrls_pkg::RATE_NETCONV);
        end
    end
    assign bit_rate_valid_out = rate_ok_r;
endmodule
`default_nettype wire

/* mrls_pkg.sv */
// Purpose: shared constants and types of the motor run and link setup block
// Assumes: 250 MHz reference clock
// Notes:   all numbers of the block live here except the sync width NSYNC in mrls_top
`default_nettype none
package mrls_pkg;
    // ------------------------------------------------------------
    // clock and timing
    // ------------------------------------------------------------
    localparam int CLK_PERIOD_NS = 4;                 // 250 MHz
    localparam int RAMP_TICK_NS  = 1000000;           // one ramp step per 1 ms
    localparam int RAMP_TICK_CYC = RAMP_TICK_NS / CLK_PERIOD_NS;
    localparam logic [1:0] CAPT_WAIT = 2'h3;          // sync fill before sampling

    // ------------------------------------------------------------
    // speed figures in r/min
    // ------------------------------------------------------------
    localparam logic [11:0] TEST_SPEED   = 12'h064;   // 100
    localparam logic [11:0] SPEED_MIN    = 12'h064;   // 100
    localparam logic [11:0] SPEED_MAX    = 12'hFA0;   // 4000
    localparam logic [11:0] SPEED_INIT   = 12'h000;   // 0
    localparam logic [9:0]  ADC_HALF_MAX = 10'h1FF;   // code of 5 V on a 10 V adc
    localparam int          SHIFT_5V     = 9;
    localparam int          SHIFT_10V    = 10;

    // ------------------------------------------------------------
    // switch defaults and codes
    // ------------------------------------------------------------
    localparam logic [3:0] RATE_9600    = 4'h0;
    localparam logic [3:0] RATE_115200  = 4'h4;
    localparam logic [3:0] RATE_NETCONV = 4'h7;
    localparam logic [4:0] ADDR_DEFAULT = 5'h00;
    localparam logic [4:0] ADDR_HIGH    = 5'h10;      // plus 16

    // ------------------------------------------------------------
    // register map (word index on the plain port)
    // ------------------------------------------------------------
    localparam logic [3:0]  REG_CTRL   = 4'h0;
    localparam logic [3:0]  REG_DECEL  = 4'h1;
    localparam logic [3:0]  REG_STATUS = 4'h2;
    localparam logic [3:0]  REG_CONFIG = 4'h3;
    localparam logic [3:0]  REG_SPEED  = 4'h4;
    localparam int          CTRL_REV   = 0;           // direction reversal
    localparam int          CTRL_SPAN  = 1;           // 1 = 0..10 V span
    localparam logic [1:0]  CTRL_RST   = 2'h0;
    localparam logic [11:0] DECEL_RST  = 12'h00A;     // r/min per ramp tick

    // ------------------------------------------------------------
    // types
    // ------------------------------------------------------------
    typedef enum logic [2:0] {
        ST_IDLE, ST_RUN, ST_DECEL, ST_TEST, ST_LOCK
    } mrls_state_e;

    typedef struct packed {
        logic       modbus;      // 1 = modbus rtu, 0 = network converter
        logic [4:0] addr;        // node address 0..31
        logic [3:0] rate;        // bit rate code
        logic       term;        // 120 ohm terminator on
        logic       regen;       // regeneration unit present
    } mrls_cfg_s;

    localparam mrls_cfg_s CFG_RST = '{1'b0, ADDR_DEFAULT, RATE_NETCONV, 1'b0, 1'b0};
endpackage
`default_nettype wire

/* mrls_top_asserts.sv */
// Purpose: port checks of mrls_top
// Assumes: bound to every mrls_top instance
// Notes:   age counter starts at each reset release
`timescale 1ns/1ps
`default_nettype none
module mrls_top_asserts (
    input wire logic        ref_clk_in,
    input wire logic        rst_n_in,
    input wire logic        test_run_switch_in,
    input wire logic        input_terminal_zero_in,
    input wire logic        input_terminal_one_in,
    input wire logic [11:0] speed_cmd_out,
    input wire logic        motor_run_out,
    input wire logic        instant_stop_out,
    input wire logic [4:0]  node_address_out,
    input wire logic [3:0]  bit_rate_code_out,
    input wire logic        bit_rate_valid_out,
    input wire logic        regen_alarm_out
);
    default clocking cb @(posedge ref_clk_in); endclocking
    default disable iff (!rst_n_in);
    logic [3:0] age_r; // cycles since release, saturates well past capture
    always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
        if (!rst_n_in) age_r <= 4'h0;
        else if (age_r != 4'hF) age_r <= age_r + 4'h1;
    end
    chk_cfg_frozen: assert property (age_r == 4'hF |->
        $stable(node_address_out) && $stable(bit_rate_code_out)) else $error("settings moved");
    chk_rate_valid: assert property (age_r == 4'hF |-> bit_rate_valid_out ==
        (bit_rate_code_out <= 4'h4 || bit_rate_code_out == 4'h7)) else $error("bad rate flag");
    chk_idle_speed: assert property (!motor_run_out |-> speed_cmd_out == 12'h000)
        else $error("speed while stopped");
    chk_speed_max: assert property (motor_run_out |-> speed_cmd_out <= 12'hFA0)
        else $error("speed above limit");
    chk_test_speed: assert property ((test_run_switch_in && !input_terminal_zero_in &&
        !input_terminal_one_in) [*6] ##0 motor_run_out |-> speed_cmd_out == 12'h064)
        else $error("test speed wrong");
    chk_both_stop: assert property ((input_terminal_zero_in && input_terminal_one_in) [*5]
        |-> !motor_run_out) else $error("runs with both inputs");
    chk_stop_pulse: assert property (instant_stop_out |-> !motor_run_out ##1
        !instant_stop_out) else $error("stop pulse wrong");
    chk_alarm_hold: assert property (regen_alarm_out |=>
        regen_alarm_out && !motor_run_out) else $error("alarm not held");
    cover property (instant_stop_out);
    cover property ($rose(regen_alarm_out));
    cover property (motor_run_out && speed_cmd_out == 12'h064);
endmodule
bind mrls_top mrls_top_asserts u_chk (.ref_clk_in, .rst_n_in, .test_run_switch_in,
    .input_terminal_zero_in, .input_terminal_one_in, .speed_cmd_out, .motor_run_out,
    .instant_stop_out, .node_address_out, .bit_rate_code_out, .bit_rate_valid_out,
    .regen_alarm_out);
`default_nettype wire

/* mrls_far_model.sv */
// Purpose: relay contacts that feed the run terminals
// Assumes: one command vector {style, ccw, cw} from the bench
// Notes:   slow mode adds one cycle of contact delay
`timescale 1ns/1ps
`default_nettype none
module mrls_far_model (
    input  wire logic       clk_in,
    input  wire logic [2:0] cmd_in,
    input  wire logic       slow_in,
    output logic [2:0]      term_out
);
    logic [2:0] held_r = 3'h0; // first contact stage
    // terminal zero is cw, one is ccw, two is stop style
    always @(posedge clk_in) held_r <= cmd_in;
    assign term_out = slow_in ? held_r : cmd_in;
endmodule
`default_nettype wire

/* tb.sv */
// Purpose: self-checking bench of mrls_top
// Assumes: ramp shortened to 4 cycles a step
// Notes:   alarm case runs last because it is sticky; a mid-run reset clears it
`timescale 1ns/1ps
`default_nettype none
module tb;
    typedef struct packed {logic [1:0] ctl; logic [9:0] ana; logic [2:0] cmd;
        logic run; logic ccw; logic [11:0] spd;} mrls_row_s;
    // unique nonzero address, valid rate code
    logic protocol_select_switch_in = 1'b1, address_high_switch_in = 1'b1;
    logic termination_switch_in = 1'b1, regen_present_in = 1'b1, regen_thermostat_in = 1'b0;
    logic [3:0] address_rotary_switch_in = 4'h5, bit_rate_switch_in = 4'h4, reg_addr_in = 4'h0;
    logic ref_clk_in = 1'b0, rst_n_in = 1'b0, test_run_switch_in = 1'b0, slow = 1'b0;
    logic reg_wr_in = 1'b0, reg_rd_in = 1'b0, motor_run_out, motor_ccw_out, instant_stop_out;
    logic protocol_modbus_out, bit_rate_valid_out, termination_en_out, regen_alarm_out;
    logic [9:0] analog_speed_in = 10'h100;
    logic [15:0] reg_wdata_in = 16'h0000, reg_rdata_out;
    logic [11:0] speed_cmd_out;
    logic [4:0] node_address_out;
    logic [3:0] bit_rate_code_out;
    logic [2:0] cmd = 3'h0, tm;
    int miscompares = 0, n_tests = 0, i;
    mrls_row_s rows [5] = '{{2'h0, 10'h100, 3'h1, 1'b1, 1'b0, 12'h7D0},
        {2'h0, 10'h3FF, 3'h2, 1'b1, 1'b1, 12'hF98}, {2'h1, 10'h001, 3'h1, 1'b1, 1'b1, 12'h064},
        {2'h2, 10'h3FF, 3'h1, 1'b1, 1'b0, 12'hF9C}, {2'h0, 10'h100, 3'h3, 1'b0, 1'b0, 12'h000}};
    always #2 ref_clk_in = ~ref_clk_in;
    mrls_far_model u_far (.clk_in(ref_clk_in), .cmd_in(cmd), .slow_in(slow), .term_out(tm));
    mrls_top #(.RAMP_TICKS(4)) u_dut (.ref_clk_in, .rst_n_in, .test_run_switch_in,
        .input_terminal_zero_in(tm[0]), .input_terminal_one_in(tm[1]),
        .input_terminal_two_in(tm[2]), .protocol_select_switch_in, .address_high_switch_in,
        .address_rotary_switch_in, .bit_rate_switch_in, .termination_switch_in,
        .regen_present_in, .regen_thermostat_in, .analog_speed_in, .reg_addr_in, .reg_wdata_in,
        .reg_wr_in, .reg_rd_in, .reg_rdata_out, .speed_cmd_out, .motor_run_out, .motor_ccw_out,
        .instant_stop_out, .protocol_modbus_out, .node_address_out, .bit_rate_code_out,
        .bit_rate_valid_out, .termination_en_out, .regen_alarm_out);
    task automatic chk(input logic [15:0] got, input logic [15:0] exp, input string nm);
        n_tests++;
        if (got !== exp) begin
            miscompares++;
            $display("[ERR] %s expected %h seen %h", nm, exp, got);
        end
    endtask
    // waits n edges, then lets the edge's updates settle
    task automatic tick(input int n);
        repeat (n) @(posedge ref_clk_in);
        #1;
    endtask
    task automatic wr(input logic [3:0] a, input logic [15:0] d);
        @(posedge ref_clk_in);
        reg_wr_in <= 1'b1;
        reg_addr_in <= a;
        reg_wdata_in <= d;
        @(posedge ref_clk_in);
        reg_wr_in <= 1'b0;
    endtask
    task automatic rd(input logic [3:0] a, input logic [15:0] exp, input string nm);
        @(posedge ref_clk_in);
        reg_rd_in <= 1'b1;
        reg_addr_in <= a;
        @(posedge ref_clk_in);
        reg_rd_in <= 1'b0;
        #1;
        chk(reg_rdata_out, exp, nm);
    endtask
    task automatic wrap_up();
        if (miscompares == 0 && n_tests > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask
    initial begin
        tick(3);
        chk({node_address_out, bit_rate_code_out, termination_en_out}, 10'h00E, "rst");
        tick(3);
        rst_n_in <= 1'b1;
        tick(10);
        chk({bit_rate_valid_out, protocol_modbus_out, node_address_out, bit_rate_code_out,
            termination_en_out}, 12'hEA9, "cfg");
        address_rotary_switch_in <= 4'hA;
        termination_switch_in <= 1'b0;
        tick(10);
        chk({node_address_out, termination_en_out}, 6'h2B, "frozen");
        rd(mrls_pkg::REG_STATUS, 16'h0010, "status");
        rd(mrls_pkg::REG_DECEL, 16'h000A, "decel");
        rd(4'hF, 16'h0000, "unmapped");
        for (i = 0; i < 5; i++) begin
            wr(mrls_pkg::REG_CTRL, {14'h0, rows[i].ctl});
            analog_speed_in <= rows[i].ana;
            cmd <= rows[i].cmd;
            tick(8);
            chk({motor_run_out, motor_ccw_out, speed_cmd_out},
                {rows[i].run, rows[i].ccw, rows[i].spd}, "row");
            cmd <= 3'h0;
            tick(8);
            chk(motor_run_out, 1'b0, "row_stop");
        end
        wr(mrls_pkg::REG_CTRL, 16'h0000);
        test_run_switch_in <= 1'b1;
        tick(8);
        chk({motor_run_out, motor_ccw_out, speed_cmd_out}, 14'h2064, "test");
        test_run_switch_in <= 1'b0;
        tick(8);
        chk(motor_run_out, 1'b0, "test_off");
        wr(mrls_pkg::REG_CTRL, 16'h0001);
        test_run_switch_in <= 1'b1;
        tick(8);
        chk({motor_run_out, motor_ccw_out}, 2'h3, "test_rev");
        cmd <= 3'h1;
        tick(8);
        chk({motor_run_out, regen_alarm_out}, 2'h0, "test_abort");
        cmd <= 3'h0;
        tick(8);
        chk(motor_run_out, 1'b0, "locked");
        test_run_switch_in <= 1'b0;
        tick(8);
        slow <= 1'b1;
        cmd <= 3'h5;
        tick(8);
        chk(motor_run_out, 1'b1, "unlocked");
        cmd <= 3'h4;
        tick(24);
        chk({motor_run_out, speed_cmd_out < 12'h7D0}, 2'h3, "ramp");
        for (i = 0; i < 3000 && motor_run_out !== 1'b0; i++) tick(1);
        chk({i < 3000, speed_cmd_out}, 13'h1000, "ramp_end");
        cmd <= 3'h1;
        tick(8);
        cmd <= 3'h0;
        for (i = 0; i < 20 && instant_stop_out !== 1'b1; i++) tick(1);
        chk(i < 20, 1'b1, "instant");
        cmd <= 3'h1;
        tick(8);
        regen_thermostat_in <= 1'b1;
        tick(8);
        chk({regen_alarm_out, motor_run_out}, 2'h2, "alarm");
        regen_thermostat_in <= 1'b0;
        rst_n_in <= 1'b0;
        tick(2);
        rst_n_in <= 1'b1;
        tick(12);
        chk({regen_alarm_out, motor_run_out, node_address_out}, 7'h3A, "rst_mid");
        wrap_up();
    end
endmodule
`default_nettype wire
